/* File: shared/asrc_cfg.svh */
// Timing counts and sizes for the static memory controller
`ifndef ASRC_CFG_SVH
`define ASRC_CFG_SVH
`define ASRC_CLK_PERIOD_PS 8000
`define ASRC_ADDR_W 18
`define ASRC_DATA_W 16
`define ASRC_WORDS 262144
// Power-up wait, in ns
`define ASRC_POWER_UP_NS 1000
`define ASRC_POWER_UP_CYC ((`ASRC_POWER_UP_NS * 1000 + `ASRC_CLK_PERIOD_PS - 1) / `ASRC_CLK_PERIOD_PS)
// Access and strobe times, in ps
`define ASRC_READ_CYCLE_PS 20000
`define ASRC_WRITE_PULSE_PS 13000
`define ASRC_ADDR_SETUP_PS 0
`define ASRC_WRITE_TO_FLOAT_DELAY_PS 8000
`define ASRC_DATA_SETUP_TIME_PS 9000
`define ASRC_CYC(ps) (((ps) + `ASRC_CLK_PERIOD_PS - 1) / `ASRC_CLK_PERIOD_PS)
`define ASRC_READ_CYC `ASRC_CYC(`ASRC_READ_CYCLE_PS)
`define ASRC_WRITE_CYC `ASRC_CYC(`ASRC_WRITE_TO_FLOAT_DELAY_PS + `ASRC_DATA_SETUP_TIME_PS)
`define ASRC_TURN_CYC 1
`endif

/* File: shared/asrc_pkg.sv */
// Types for the static memory controller
package asrc_pkg;
  typedef enum logic [2:0] {
    ASRC_POWERUP = 3'h0,
    ASRC_IDLE = 3'h1,
    ASRC_READ = 3'h3,
    ASRC_WRITE = 3'h2,
    ASRC_TURN = 3'h6
  } asrc_state_t;
endpackage

/* File: logic/asrc_timer.sv */
// Down-counter that times each phase of an access
`timescale 1ns/1ps
module asrc_timer #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic done
);
  logic [W-1:0] cnt_q;
  assign done = (cnt_q == '0);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (load)
      cnt_q <= count;
    else if (!done)
      cnt_q <= cnt_q - 1'b1;
  end
endmodule // asrc_timer

/* File: logic/asrc_ctrl.sv */
// Host controller for an asynchronous 256K x 16 static memory
`timescale 1ns/1ps
`include "asrc_cfg.svh"
// Contract
// [RULE1] Memory holds 262,144 words of 16 bits, two byte lanes, 18-bit address.
// [RULE2] Write happens while chip select and write strobe are both low.
// [RULE3] Lower lane enable low stores data bits 7..0 on write.
// [RULE4] Upper lane enable low stores bits 15..8; disabled lane keeps contents.
// [RULE5] Read: chip select and output strobe low, write strobe high.
// [RULE6] Lower lane enable low drives low read byte onto bits 7..0.
// [RULE7] Upper lane enable low drives high read byte onto bits 15..8.
// [RULE8] Memory floats data whenever chip select is high.
// [RULE9] Memory floats data if output strobe high or both lanes disabled.
// [RULE10] Memory does not drive data during a write.
// [RULE11] Chip select high puts the memory in standby, contents kept.
// [RULE12] Host waits at least 1 us after power-up before first access.
// [RULE13] Write is the overlap of select and strobe; ending edge captures data.
// [RULE14] Select and strobe rising together leaves data floating.
// [RULE15] Strobe-ended write with output strobe low lasts float delay plus setup.
// [RULE16] Write proceeds regardless of output strobe; single-lane writes allowed.
// [RULE17] Single-lane read drives only that lane's data bits.
module asrc_ctrl
  import asrc_pkg::*;
#(
  parameter int POWER_UP_CYC = `ASRC_POWER_UP_CYC,
  parameter int READ_CYC = `ASRC_READ_CYC,
  parameter int WRITE_CYC = `ASRC_WRITE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [`ASRC_ADDR_W-1:0] req_addr,
  input wire logic [`ASRC_DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_lane_en,
  output logic rsp_valid,
  output logic [`ASRC_DATA_W-1:0] rsp_rdata,
  output logic mem_ready,
  output logic [`ASRC_ADDR_W-1:0] sram_addr,
  output logic sram_chip_sel_n,
  output logic sram_write_n,
  output logic sram_out_en_n,
  output logic lower_lane_enable_n,
  output logic upper_lane_enable_n,
  input wire logic [`ASRC_DATA_W-1:0] sram_data_i,
  output logic [`ASRC_DATA_W-1:0] sram_data_o,
  output logic sram_data_oe
);
  localparam int TW = 10;
  // Phase lengths load as count minus one, since the timer finishes on zero
  function automatic logic [TW-1:0] load_of(input int cyc);
    return TW'(cyc - 1);
  endfunction
  // ==========================================================
  // State and pin registers
  asrc_state_t state_q, state_d;
  logic [`ASRC_ADDR_W-1:0] addr_q;
  logic [`ASRC_DATA_W-1:0] wdata_q, rdata_q;
  logic [1:0] lane_q;
  logic cs_n_q, we_n_q, oe_n_q, doe_q, rsp_q;
  logic t_load, t_done;
  logic [TW-1:0] t_count;
  // ==========================================================
  // Phase timing
  // One timer serves every phase, since phases never overlap
  asrc_timer #(.W(TW)) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .load(t_load),
    .count(t_count),
    .done(t_done)
  );
  wire idle_st = (state_q == ASRC_IDLE);
  wire take = idle_st && req_valid;
  wire [1:0] lane_sel = req_lane_en;
  wire [TW-1:0] acc_load = req_write ? load_of(WRITE_CYC) : load_of(READ_CYC); // RULE15
  // Requests are taken only in idle, one access at a time
  assign req_ready = idle_st;
  // Nothing is taken before the power-up wait ends
  assign mem_ready = (state_q != ASRC_POWERUP); // RULE12
  // Reset leaves the timer at zero, so power-up wait is loaded on the first edge
  logic pu_loaded_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pu_loaded_q <= 1'b0;
    else
      pu_loaded_q <= 1'b1;
  end
  always_comb
  begin
    state_d = state_q;
    t_load = 1'b0;
    t_count = '0;
    case (state_q)
      ASRC_POWERUP:
      begin
        if (!pu_loaded_q)
        begin
          t_load = 1'b1;
          t_count = load_of(POWER_UP_CYC); // RULE12
        end
        else if (t_done)
          state_d = ASRC_IDLE; // RULE12
      end
      ASRC_IDLE:
      begin
        if (take)
        begin
          t_load = 1'b1;
          t_count = acc_load; // RULE15
          state_d = req_write ? ASRC_WRITE : ASRC_READ;
        end
      end
      ASRC_READ:
      begin
        if (t_done)
          state_d = ASRC_TURN;
      end
      ASRC_WRITE:
      begin
        if (t_done)
          state_d = ASRC_TURN; // RULE13
      end
      // Idle cycle lets the data drivers turn around
      ASRC_TURN:
        state_d = ASRC_IDLE;
      default:
        state_d = ASRC_IDLE;
    endcase
  end
  // ==========================================================
  // Access end decode
  wire rd_end = (state_q == ASRC_READ) && t_done;
  wire wr_end = (state_q == ASRC_WRITE) && t_done;
  wire acc_end = rd_end || wr_end;
  wire turn_st = (state_q == ASRC_TURN);
  // Disabled lanes read back as zero
  wire [`ASRC_DATA_W-1:0] lane_mask = {{8{~lane_q[1]}}, {8{~lane_q[0]}}}; // RULE17
  // ==========================================================
  // Next pin levels; select held high outside accesses for standby
  wire [`ASRC_ADDR_W-1:0] addr_d = take ? req_addr : addr_q; // RULE1
  wire [`ASRC_DATA_W-1:0] wdata_d = take ? req_wdata : wdata_q;
  // Strobe and select rise together, so the memory never turns its drivers on as a write ends
  wire cs_n_d = take ? 1'b0 : acc_end ? 1'b1 : cs_n_q; // RULE2 RULE5 RULE11 RULE14
  wire we_n_d = take ? ~req_write : wr_end ? 1'b1 : we_n_q; // RULE2 RULE13
  wire oe_n_d = take ? req_write : rd_end ? 1'b1 : oe_n_q; // RULE5 RULE9 RULE16
  // Write data stays one cycle past the ending edge for hold
  wire doe_d = take ? req_write : turn_st ? 1'b0 : doe_q; // RULE10 RULE13
  wire [1:0] lane_d = take ? ~lane_sel : (rd_end || turn_st) ? 2'h3 : lane_q; // RULE3 RULE4
  wire [`ASRC_DATA_W-1:0] rdata_d = rd_end ? (sram_data_i & lane_mask) : rdata_q; // RULE6 RULE7
  // ==========================================================
  // Registers; strobes reset high so the memory idles in standby
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= ASRC_POWERUP;
    else
      state_q <= state_d;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_n_q <= 1'b1;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
    end
    else
    begin
      cs_n_q <= cs_n_d;
      we_n_q <= we_n_d;
      oe_n_q <= oe_n_d;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lane_q <= 2'h3;
    else
      lane_q <= lane_d;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_q <= '0;
      wdata_q <= '0;
    end
    else
    begin
      addr_q <= addr_d;
      wdata_q <= wdata_d;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      doe_q <= 1'b0;
    else
      doe_q <= doe_d;
  end
  // Read data is masked before the flop, so the output comes straight from it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_q <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      rsp_q <= rd_end;
      rdata_q <= rdata_d;
    end
  end
  assign sram_addr = addr_q; // RULE1
  assign sram_chip_sel_n = cs_n_q;
  assign sram_write_n = we_n_q;
  assign sram_out_en_n = oe_n_q;
  assign lower_lane_enable_n = lane_q[0];
  assign upper_lane_enable_n = lane_q[1];
  assign sram_data_o = wdata_q;
  assign sram_data_oe = doe_q;
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
endmodule // asrc_ctrl

/* File: bench/asrc_sram_model.sv */
// Behavioural static memory on the far side of the controller
`timescale 1ns/1ps
`include "asrc_cfg.svh"
module asrc_sram_model (
  input wire logic [17:0] addr,
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic lo_n,
  input wire logic hi_n,
  input wire logic [15:0] d,
  output logic [15:0] q
);
  logic [15:0] mem [`ASRC_WORDS];
  wire wr_end = cs_n | we_n;
  wire rd = !cs_n && !oe_n && we_n;
  // Capture on the ending edge, either strobe
  always @(posedge wr_end)
  begin
    if (!lo_n)
      mem[addr][7:0] = d[7:0];
    if (!hi_n)
      mem[addr][15:8] = d[15:8];
  end
  // Floating lanes show inverted data, never a stale copy
  assign q = {(rd && !hi_n) ? mem[addr][15:8] : ~mem[addr][15:8],
    (rd && !lo_n) ? mem[addr][7:0] : ~mem[addr][7:0]};
endmodule // asrc_sram_model

/* File: bench/asrc_ctrl_assertions.sv */
// Pin checks for the static memory controller
`timescale 1ns/1ps
module asrc_ctrl_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mem_ready,
  input wire logic sram_chip_sel_n,
  input wire logic sram_write_n,
  input wire logic sram_out_en_n,
  input wire logic sram_data_oe
);
  logic [7:0] up_q;
  // Saturates so long runs do not wrap
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      up_q <= 8'h00;
    else if (up_q != 8'hFF)
      up_q <= up_q + 8'h01;
  AST_POWER_UP: assert property (@(posedge clk) disable iff (!rst_n)
    !sram_chip_sel_n |-> mem_ready && up_q >= 8'h7D) else $error("access before power-up");
  AST_WRITE_DRIVE: assert property (@(posedge clk) disable iff (!rst_n)
    !sram_chip_sel_n && !sram_write_n |-> sram_data_oe && sram_out_en_n) else $error("bad write");
  AST_READ: assert property (@(posedge clk) disable iff (!rst_n)
    !sram_chip_sel_n && !sram_out_en_n |-> sram_write_n && !sram_data_oe) else $error("bad read");
  AST_WRITE_LEN: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(sram_write_n) |-> (!sram_chip_sel_n && !sram_write_n) [*3] ##1
    (sram_chip_sel_n && sram_write_n)) else $error("write length wrong");
  AST_DATA_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(sram_write_n) |-> sram_data_oe ##1 !sram_data_oe) else $error("no data hold");
  AST_STANDBY: assert property (@(posedge clk) disable iff (!rst_n)
    sram_chip_sel_n |-> sram_write_n && sram_out_en_n) else $error("strobe while deselected");
endmodule // asrc_ctrl_assertions
bind asrc_ctrl asrc_ctrl_assertions u_chk (.clk(clk), .rst_n(rst_n), .mem_ready(mem_ready),
  .sram_chip_sel_n(sram_chip_sel_n), .sram_write_n(sram_write_n),
  .sram_out_en_n(sram_out_en_n), .sram_data_oe(sram_data_oe));

/* File: bench/tb.sv */
// Self-checking bench for the static memory controller
`timescale 1ns/1ps
module tb;
  logic clk = 0;
  logic rst_n = 0;
  logic req_valid = 0;
  logic req_write = 0;
  logic [17:0] req_addr = 18'h0;
  logic [15:0] req_wdata = 16'h0;
  logic [1:0] req_lane_en = 2'h0;
  logic req_ready, rsp_valid, mem_ready, sram_chip_sel_n, sram_write_n, sram_out_en_n;
  logic lower_lane_enable_n, upper_lane_enable_n, sram_data_oe;
  logic [17:0] sram_addr;
  logic [15:0] rsp_rdata, sram_data_o, mq;
  wire [15:0] sram_data_i = sram_data_oe ? sram_data_o : mq;
  int n_errors = 0;
  int n_checks = 0;
  asrc_ctrl uut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_lane_en(req_lane_en), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .mem_ready(mem_ready), .sram_addr(sram_addr), .sram_chip_sel_n(sram_chip_sel_n),
    .sram_write_n(sram_write_n), .sram_out_en_n(sram_out_en_n),
    .lower_lane_enable_n(lower_lane_enable_n), .upper_lane_enable_n(upper_lane_enable_n),
    .sram_data_i(sram_data_i), .sram_data_o(sram_data_o), .sram_data_oe(sram_data_oe));
  asrc_sram_model u_mem (.addr(sram_addr), .cs_n(sram_chip_sel_n), .we_n(sram_write_n),
    .oe_n(sram_out_en_n), .lo_n(lower_lane_enable_n), .hi_n(upper_lane_enable_n),
    .d(sram_data_i), .q(mq));
  initial forever #4 clk = ~clk;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(string nm, logic [15:0] s, logic [15:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wait_on(bit rsp);
    for (int i = 0; i < 300; i++)
    begin
      if ((rsp ? rsp_valid : req_ready) === 1'b1)
        return;
      @(posedge clk);
      #1;
    end
    n_errors++;
    complete_run();
  endtask
  task automatic access(bit wr, logic [17:0] a, logic [15:0] d, logic [1:0] ln);
    wait_on(0);
    req_valid = 1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    req_lane_en = ln;
    @(posedge clk);
    #1;
    req_valid = 0;
    if (!wr)
      wait_on(1);
  endtask
  task automatic t_power();
    int c = 0;
    while (mem_ready !== 1'b1 && c < 300)
    begin
      check("ready", req_ready, 16'h0);
      @(posedge clk);
      #1;
      c++;
    end
    check("wait", 16'(c >= 125), 16'h1);
    check("powered", mem_ready, 16'h1);
    $display("power-up test done");
  endtask
  task automatic t_full();
    access(1, 18'h3FFFF, 16'hA5C3, 2'h3);
    access(1, 18'h00000, 16'h0F0F, 2'h3);
    access(0, 18'h3FFFF, 16'h0, 2'h3);
    check("word", rsp_rdata, 16'hA5C3);
    @(posedge clk);
    #1;
    check("pulse", rsp_valid, 16'h0);
    access(0, 18'h00000, 16'h0, 2'h3);
    check("word0", rsp_rdata, 16'h0F0F);
    $display("full word test done");
  endtask
  task automatic t_lanes();
    logic [15:0] e [4] = '{16'h0000, 16'h0034, 16'h5600, 16'h5634};
    access(1, 18'h3FFFF, 16'h1234, 2'h1);
    access(1, 18'h3FFFF, 16'h5678, 2'h2);
    for (int l = 0; l < 4; l++)
    begin
      access(0, 18'h3FFFF, 16'h0, l[1:0]);
      check("lane", rsp_rdata, e[l]);
    end
    $display("lane test done");
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1;
    t_power();
    t_full();
    t_lanes();
    complete_run();
  end
endmodule // tb
